// ===== bench/csp_card_model.sv
// Card contact model: resolves each pin from driver and pulls.
// Assumes the block's pad outputs; a floating pin flips each cycle.
`timescale 1ns/1ps
`default_nettype none
module csp_card_model
  import csp_pkg::*;
(
  input wire logic aclk,
  input wire logic [CSP_NUM_PINS-1:0] pin_o,
  input wire logic [CSP_NUM_PINS-1:0] pin_oe_n,
  input wire logic [CSP_NUM_PINS-1:0] pull_up,
  input wire logic [CSP_NUM_PINS-1:0] pull_dn,
  output logic [CSP_NUM_PINS-1:0] pin_lvl
);
  logic flip_r = 1'b0;
  // Pattern for floating pins, so no stale level is read
  always_ff @(posedge aclk) begin
    flip_r <= !flip_r;
  end
  // Driver first, then pulls, else the pattern
  always_comb begin
    for (int i = 0; i < CSP_NUM_PINS; i++) begin
      pin_lvl[i] = !pin_oe_n[i] ? pin_o[i] : pull_up[i] ? 1'b1 : pull_dn[i] ? 1'b0 : flip_r;
    end
  end
endmodule
`default_nettype wire

// ===== bench/csp_pad_ctrl_test.sv
// Testbench for the card pad block: register and pad tests.
// Assumes the card model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module csp_pad_ctrl_test;
  import csp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, smode;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] pin_i, pin_o, oe_n, wup, wdn;
  logic [7:0] offs [3] = '{CSP_OFF_CARD_CLOCK, CSP_OFF_FUNCTION, CSP_OFF_SUPPLY};
  int failures = 0;
  int checks_done = 0;
  csp_pad_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .card_pin_i(pin_i), .card_pin_o(pin_o), .card_pin_oe_n(oe_n), .weak_high_bias(wup),
    .weak_low_bias(wdn), .sync_mode_active(smode));
  csp_card_model u_card (.aclk, .pin_o, .pin_oe_n(oe_n), .pull_up(wup), .pull_dn(wdn),
    .pin_lvl(pin_i));
  // Clock of 4 ns
  initial forever #2 aclk = ~aclk;
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic chk3(input logic [2:0] seen, input logic [2:0] exp);
    chk(32'(seen), 32'(exp));
  endtask
  // Write; returns 1 ns after the edge at which the pads follow
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    #1;
  endtask
  // Read after the input flops have settled
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    repeat (3) @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ex);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    failures++;
    complete_run();
  end
  // Test sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0000_0000, CSP_RESP_OKAY);
    chk3(oe_n, 3'h7);
    chk3(wup | wdn, 3'h0);
    $display("test reset done");
    wr(CSP_OFF_FUNCTION, 32'hFFFF_FFFF, CSP_RESP_OKAY);
    chk3(wup & wdn, 3'h2);
    chk3(oe_n, 3'h7);
    rd(CSP_OFF_FUNCTION, 32'h0000_3F01, CSP_RESP_OKAY);
    wr(8'h40, 32'h0000_0001, CSP_RESP_SLVERR);
    rd(8'h40, 32'h0000_0000, CSP_RESP_SLVERR);
    $display("test reserved done");
    wr(CSP_OFF_MUX_SELECT, 32'h0000_0001, CSP_RESP_OKAY);
    wr(CSP_OFF_FUNCTION, 32'h0000_3001, CSP_RESP_OKAY);
    chk3({oe_n[1], pin_o[1], wdn[1]}, 3'h2);
    rd(CSP_OFF_FUNCTION, 32'h0000_3003, CSP_RESP_OKAY);
    wr(CSP_OFF_FUNCTION, 32'h0000_1001, CSP_RESP_OKAY);
    rd(CSP_OFF_FUNCTION, 32'h0000_1001, CSP_RESP_OKAY);
    wr(CSP_OFF_FUNCTION, 32'h0000_0001, CSP_RESP_OKAY);
    chk3(oe_n, 3'h7);
    $display("test function done");
    wr(CSP_OFF_SUPPLY, 32'h0000_3400, CSP_RESP_OKAY);
    chk3({oe_n[2], pin_o[2], 1'b0}, 3'h0);
    wr(CSP_OFF_SUPPLY, 32'h0000_3601, CSP_RESP_OKAY);
    chk3({oe_n[2], wup[2], wdn[2]}, 3'h6);
    rd(CSP_OFF_SUPPLY, 32'h0000_3603, CSP_RESP_OKAY);
    wr(CSP_OFF_SUPPLY, 32'h0000_3501, CSP_RESP_OKAY);
    rd(CSP_OFF_SUPPLY, 32'h0000_3501, CSP_RESP_OKAY);
    $display("test supply done");
    wr(CSP_OFF_FUNCTION, 32'h0000_1800, CSP_RESP_OKAY);
    wr(CSP_OFF_FUNCTION, 32'h0000_1801, CSP_RESP_OKAY);
    chk3({oe_n[1], pin_o[1], 1'b0}, 3'h2);
    @(posedge aclk);
    #1;
    chk3({2'b00, oe_n[1]}, 3'h1);
    // Level lane only: the configuration bits must stay as they were
    wstrb <= 4'h1;
    wr(CSP_OFF_FUNCTION, 32'h0000_3000, CSP_RESP_OKAY);
    wstrb <= 4'hf;
    rd(CSP_OFF_FUNCTION, 32'h0000_1800, CSP_RESP_OKAY);
    $display("test fast done");
    wr(CSP_OFF_CARD_CLOCK, 32'h0000_3001, CSP_RESP_OKAY);
    chk3({2'b00, oe_n[0]}, 3'h1);
    rd(CSP_OFF_CARD_CLOCK, 32'h0000_3001, CSP_RESP_OKAY);
    wr(CSP_OFF_SC_CONTROL, 32'h0000_0001, CSP_RESP_OKAY);
    chk3({smode, oe_n[0], pin_o[0]}, 3'h5);
    rd(CSP_OFF_CARD_CLOCK, 32'h0000_3003, CSP_RESP_OKAY);
    wr(CSP_OFF_CARD_CLOCK, 32'h0000_3000, CSP_RESP_OKAY);
    chk3({smode, oe_n[0], pin_o[0]}, 3'h4);
    rd(CSP_OFF_CARD_CLOCK, 32'h0000_3000, CSP_RESP_OKAY);
    $display("test clock done");
    complete_run();
  end
endmodule
`default_nettype wire

// ===== bench/csp_properties.sv
// Port assertions for the card pad block.
// Bound to the block; one clock domain, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module csp_pad_props
  import csp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [CSP_NUM_PINS-1:0] card_pin_oe_n,
  input wire logic [CSP_NUM_PINS-1:0] weak_high_bias,
  input wire logic [CSP_NUM_PINS-1:0] weak_low_bias,
  input wire logic sync_mode_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Bus answers stand until taken; read data keeps its reserved bits clear
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  property p_rz; s_axi_rvalid |-> s_axi_rdata[31:14] == '0 && s_axi_rdata[7:2] == '0;
  endproperty
  a_rz: assert property (p_rz) else $error("reserved bits set");
  // Mode, pulls and driver turn-on change only after a register commit; the clock pin stays undriven outside sync mode
  property p_ck; !sync_mode_active && !$past(sync_mode_active) |-> card_pin_oe_n[0];
  endproperty
  a_ck: assert property (p_ck) else $error("clock pin driven");
  property p_sm; $changed(sync_mode_active) |-> s_axi_bvalid && !$past(s_axi_bvalid);
  endproperty
  a_sm: assert property (p_sm) else $error("mode moved alone");
  property p_up; $changed(weak_high_bias) |-> s_axi_bvalid && !$past(s_axi_bvalid);
  endproperty
  a_up: assert property (p_up) else $error("pull-up moved alone");
  property p_dn; $changed(weak_low_bias) |-> s_axi_bvalid && !$past(s_axi_bvalid);
  endproperty
  a_dn: assert property (p_dn) else $error("pull-down moved alone");
  property p_dr; ($past(card_pin_oe_n) & ~card_pin_oe_n) != '0 |-> $past(s_axi_bvalid);
  endproperty
  a_dr: assert property (p_dr) else $error("driver on alone");
endmodule
bind csp_pad_ctrl csp_pad_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .card_pin_oe_n,
  .weak_high_bias, .weak_low_bias, .sync_mode_active);
`default_nettype wire

// ===== common/csp_pkg.sv
// Package for the card contact pad control block: register map,
// field positions, reset values, bus codes and the carrier structs.
// Assumes one system clock and an AXI4-Lite register bus of 32 bits.
package csp_pkg;

  // Register byte offsets
  localparam logic [7:0] CSP_OFF_SC_CONTROL = 8'h80;
  localparam logic [7:0] CSP_OFF_MUX_SELECT = 8'h84;
  localparam logic [7:0] CSP_OFF_CARD_CLOCK = 8'h94;
  localparam logic [7:0] CSP_OFF_FUNCTION = 8'h98;
  localparam logic [7:0] CSP_OFF_SUPPLY = 8'h9c;

  // Pin indices within the pad vectors
  localparam logic [1:0] CSP_PIN_CLOCK = 2'd0;
  localparam logic [1:0] CSP_PIN_FUNCTION = 2'd1;
  localparam logic [1:0] CSP_PIN_SUPPLY = 2'd2;
  localparam logic [1:0] CSP_PIN_NONE = 2'd3;
  localparam int CSP_NUM_PINS = 3;

  // Pin control register field positions
  localparam int CSP_BIT_INPUT_EN = 13;
  localparam int CSP_BIT_OUTPUT_EN = 12;
  localparam int CSP_BIT_FAST_OD = 11;
  localparam int CSP_BIT_OPEN_DRAIN = 10;
  localparam int CSP_BIT_PULL_UP = 9;
  localparam int CSP_BIT_PULL_DN = 8;
  localparam int CSP_BIT_SAMPLE = 1;
  localparam int CSP_BIT_LEVEL = 0;
  // Control register fields
  localparam int CSP_BIT_SYNC_MODE = 0;
  localparam int CSP_BIT_CARD_SELECT = 0;

  // Reset values
  localparam logic [31:0] CSP_PIN_RESET = 32'h0000_0000;
  localparam logic [31:0] CSP_CTL_RESET = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] CSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] CSP_RESP_SLVERR = 2'b10;

  // Per-pin configuration as held in its register
  typedef struct packed {
    logic in_en;
    logic out_en;
    logic fast;
    logic od;
    logic pull_up;
    logic pull_dn;
    logic level;
  } csp_pin_s;

  // Pad-side signals of one pin
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev_level;
    logic pad_o;
    logic pad_oe_n;
  } csp_pad_s;

  // Whole state of the block
  typedef struct packed {
    csp_pin_s [CSP_NUM_PINS-1:0] pin;
    csp_pad_s [CSP_NUM_PINS-1:0] pad;
    logic sync_mode;
    logic card_select;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csp_state_s;

endpackage

// ===== rtl/csp_pad_ctrl.sv
// Software pad control for the card clock, function and supply contacts.
// Assumes an AXI4-Lite master on aclk and raw pad levels from the pins.
//
// Contract
// RULE1 - Bit 13 of each pin register enables that pin's input receiver.
// RULE2 - Bit 12 of each pin register enables that pin's output driver.
// RULE3 - Bit 11 drives low for zero and pushes high one cycle on a rise, then releases.
// RULE4 - Bit 10 drives open drain: zero driven low, one released.
// RULE5 - Bit 9 turns on the pin's weak pull-up.
// RULE6 - Bit 8 turns on the pin's weak pull-down.
// RULE7 - Card clock bit 1 reads the pin level in card mode with synchronous mode on.
// RULE8 - Card clock bit 0 sets the pin level in card mode with synchronous mode on.
// RULE9 - Function bit 1 reads the pin level in card mode, either sync mode.
// RULE10 - Function bit 0 sets the pin level in card mode, either sync mode.
// RULE11 - Supply bit 1 reads the pin level in card mode, either sync mode.
// RULE12 - Supply bit 0 sets the pin level in card mode, either sync mode.
// RULE13 - Control bit 0 selects synchronous mode, freeing the clock pin for software.
// RULE14 - Reserved pin register bits read zero and ignore writes; all clear on reset.
// RULE15 - The input bit passes two flops and reads zero with the receiver off.
`timescale 1ns/1ps
`default_nettype none

module csp_pad_ctrl
  import csp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CSP_NUM_PINS-1:0] card_pin_i,
  output logic [CSP_NUM_PINS-1:0] card_pin_o,
  output logic [CSP_NUM_PINS-1:0] card_pin_oe_n,
  output logic [CSP_NUM_PINS-1:0] weak_high_bias,
  output logic [CSP_NUM_PINS-1:0] weak_low_bias,
  output logic sync_mode_active
);

  csp_state_s st_r;
  csp_state_s st_nxt;

  // Map a byte address onto a pin index
  function automatic logic [1:0] pin_index(input logic [7:0] addr);
    logic [1:0] idx;
    idx = CSP_PIN_NONE;
    unique case (addr)
      CSP_OFF_CARD_CLOCK: idx = CSP_PIN_CLOCK;
      CSP_OFF_FUNCTION: idx = CSP_PIN_FUNCTION;
      CSP_OFF_SUPPLY: idx = CSP_PIN_SUPPLY;
      default: idx = CSP_PIN_NONE;
    endcase
    return idx;
  endfunction

  // Pin is under software control in the present mux and mode setting
  function automatic logic pin_active(input logic [1:0] idx, input logic sel,
                                      input logic sync);
    logic act;
    act = sel;
    if (idx == CSP_PIN_CLOCK) begin
      act = sel & sync; // RULE7 RULE8 RULE13
    end
    return act;
  endfunction

  // Narrow bus address to the byte offset width
  function automatic logic [7:0] byte_addr(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'h00;
    a = 8'(addr);
    a[1:0] = 2'b00;
    return a;
  endfunction

  // Pin register read image
  function automatic logic [31:0] pin_word(input csp_pin_s p, input logic sample,
                                           input logic act);
    logic [31:0] w;
    w = 32'h0000_0000; // RULE14
    w[CSP_BIT_INPUT_EN] = p.in_en;
    w[CSP_BIT_OUTPUT_EN] = p.out_en;
    w[CSP_BIT_FAST_OD] = p.fast;
    w[CSP_BIT_OPEN_DRAIN] = p.od;
    w[CSP_BIT_PULL_UP] = p.pull_up;
    w[CSP_BIT_PULL_DN] = p.pull_dn;
    w[CSP_BIT_SAMPLE] = sample & p.in_en & act; // RULE1 RULE15 RULE7 RULE9 RULE11
    w[CSP_BIT_LEVEL] = p.level;
    return w;
  endfunction

  // Handshake outputs
  assign s_axi_awready = ~st_r.aw_hold;
  assign s_axi_wready = ~st_r.w_hold;
  assign s_axi_arready = ~st_r.rvalid;

  // Registered data outputs
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign sync_mode_active = st_r.sync_mode;

  // Pad outputs, all from flops
  always_comb begin
    for (int i = 0; i < CSP_NUM_PINS; i++) begin
      card_pin_o[i] = st_r.pad[i].pad_o;
      card_pin_oe_n[i] = st_r.pad[i].pad_oe_n;
      weak_high_bias[i] = st_r.pin[i].pull_up; // RULE5
      weak_low_bias[i] = st_r.pin[i].pull_dn; // RULE6
    end
  end

  // Next-state logic for bus, registers and pads
  always_comb begin
    logic [1:0] widx;
    logic [1:0] ridx;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic act;
    logic drive;
    logic rise;
    csp_pin_s p;
    widx = CSP_PIN_NONE;
    ridx = CSP_PIN_NONE;
    waddr = 8'h00;
    raddr = 8'h00;
    act = 1'b0;
    drive = 1'b0;
    rise = 1'b0;
    p = '0;
    st_nxt = st_r;

    // Write address and data are taken in either order
    if (s_axi_awvalid && !st_r.aw_hold) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.awaddr = byte_addr(s_axi_awaddr);
    end
    if (s_axi_wvalid && !st_r.w_hold) begin
      st_nxt.w_hold = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    // Response accepted
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Commit a write once both halves are held and no response is pending
    if (st_r.aw_hold && st_r.w_hold && !st_r.bvalid) begin
      waddr = st_r.awaddr;
      widx = pin_index(waddr);
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = CSP_RESP_OKAY;
      if (widx != CSP_PIN_NONE) begin
        p = st_r.pin[widx];
        if (st_r.wstrb[0]) begin
          p.level = st_r.wdata[CSP_BIT_LEVEL]; // RULE8 RULE10 RULE12
        end
        if (st_r.wstrb[1]) begin
          p.in_en = st_r.wdata[CSP_BIT_INPUT_EN];
          p.out_en = st_r.wdata[CSP_BIT_OUTPUT_EN];
          p.fast = st_r.wdata[CSP_BIT_FAST_OD];
          p.od = st_r.wdata[CSP_BIT_OPEN_DRAIN];
          p.pull_up = st_r.wdata[CSP_BIT_PULL_UP];
          p.pull_dn = st_r.wdata[CSP_BIT_PULL_DN];
        end
        st_nxt.pin[widx] = p; // RULE14
      end else if (waddr == CSP_OFF_SC_CONTROL) begin
        if (st_r.wstrb[0]) begin
          st_nxt.sync_mode = st_r.wdata[CSP_BIT_SYNC_MODE]; // RULE13
        end
      end else if (waddr == CSP_OFF_MUX_SELECT) begin
        if (st_r.wstrb[0]) begin
          st_nxt.card_select = st_r.wdata[CSP_BIT_CARD_SELECT];
        end
      end else begin
        st_nxt.bresp = CSP_RESP_SLVERR;
      end
    end

    // Read data accepted
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Read answered at the edge that takes the address
    if (s_axi_arvalid && !st_r.rvalid) begin
      raddr = byte_addr(s_axi_araddr);
      ridx = pin_index(raddr);
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = CSP_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (ridx != CSP_PIN_NONE) begin
        act = pin_active(ridx, st_r.card_select, st_r.sync_mode);
        st_nxt.rdata = pin_word(st_r.pin[ridx], st_r.pad[ridx].sync2, act);
      end else if (raddr == CSP_OFF_SC_CONTROL) begin
        st_nxt.rdata[CSP_BIT_SYNC_MODE] = st_r.sync_mode;
      end else if (raddr == CSP_OFF_MUX_SELECT) begin
        st_nxt.rdata[CSP_BIT_CARD_SELECT] = st_r.card_select;
      end else begin
        st_nxt.rresp = CSP_RESP_SLVERR;
      end
    end

    // Pad drivers and input synchronisers
    for (int i = 0; i < CSP_NUM_PINS; i++) begin
      p = st_r.pin[i];
      act = pin_active(2'(i), st_r.card_select, st_r.sync_mode);
      drive = act & p.out_en; // RULE2
      rise = p.level & ~st_r.pad[i].prev_level;
      st_nxt.pad[i].sync1 = card_pin_i[i]; // RULE15
      st_nxt.pad[i].sync2 = st_r.pad[i].sync1; // RULE15
      st_nxt.pad[i].prev_level = p.level;
      st_nxt.pad[i].pad_o = 1'b0;
      st_nxt.pad[i].pad_oe_n = 1'b1;
      if (drive) begin
        if (p.fast) begin
          // Low for zero, one push high on a rise, then released
          if (!p.level) begin
            st_nxt.pad[i].pad_oe_n = 1'b0; // RULE3
          end else if (rise) begin
            st_nxt.pad[i].pad_o = 1'b1; // RULE3
            st_nxt.pad[i].pad_oe_n = 1'b0;
          end
        end else if (p.od) begin
          // Zero pulls low, one leaves the pad to the pull-up
          st_nxt.pad[i].pad_oe_n = p.level; // RULE4
        end else begin
          // Push-pull
          st_nxt.pad[i].pad_o = p.level;
          st_nxt.pad[i].pad_oe_n = 1'b0;
        end
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0; // RULE14
      for (int i = 0; i < CSP_NUM_PINS; i++) begin
        st_r.pin[i] <= csp_pin_s'(CSP_PIN_RESET[6:0]);
        st_r.pad[i].pad_oe_n <= 1'b1;
      end
      st_r.sync_mode <= CSP_CTL_RESET[CSP_BIT_SYNC_MODE];
      st_r.card_select <= CSP_CTL_RESET[CSP_BIT_CARD_SELECT];
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

`default_nettype wire
